// ### hw/occ_cfg.svh
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH
// ******************************
// timing
// ******************************
`define CLK_HZ      125000000
`define TICK_S      1
`define HOLD_S      5
// ******************************
// register byte offsets
// ******************************
`define A_CTRL      8'h00
`define A_SETPT     8'h04
`define A_ALM_OCC   8'h08
`define A_ALM_UNOCC 8'h0C
`define A_DELAY     8'h10
`define A_SASH      8'h14
`define A_TLIM      8'h18
`define A_TCFG      8'h1C
`define A_KEY       8'h20
`define A_STATUS    8'h28
`define A_TEMP      8'h2C
`define A_ACT_SP    8'h30
`define A_ACT_ALM   8'h34
// ******************************
// control bits
// ******************************
`define C_DUAL      0
`define C_IN2_OCC   1
`define C_IN3_TEMP  2
`define C_UNITS_F   3
`define C_SHOW_T    4
`define C_SASH_SW   5
`define C_REPEAT    6
`define C_MANUAL    7
`define C_SASH_EN   8
`define CTRL_W      9
`define K_EXIT      30
`define K_SETPW     31
`define S_MUTE      0
// ******************************
// reset values and limits
// ******************************
`define RST_CTRL    9'h000
`define RST_SETPT   32'h001E_0032
`define RST_AOCC    32'h002D_0028
`define RST_AUNOCC  32'h001B_0018
`define RST_DELAY   32'h003C_001E
`define RST_SASH    32'h012C_0064
`define RST_TLIM    32'h0190_0064
`define RST_TCFG    32'h0000_1000
`define RST_PASS    16'h0000
`define DLY_MAX     16'h012C
`define T_MAX       16'sh03E8
`define T_MIN       16'sh0000
`define OFS_MAX     16'sh0032
`define OFS_MIN     -16'sh0032
`define F_NUM       20'sh0_0009
`define F_DEN       20'sh0_0005
`define F_ZERO      20'sh0_0140
`define RESP_OK     2'h0
`define RESP_ERR    2'h2
`endif

// ### hw/occ_pkg.sv
package occ_pkg;
  // active set point and its two alarm thresholds
  typedef struct packed {
    logic [15:0] setpt;
    logic [15:0] low_air;
    logic [15:0] warn;
  } airflow_t;

  typedef enum logic [1:0] {
    LBL_NONE   = 2'b00,
    LBL_HIGH   = 2'b01,
    LBL_LOW    = 2'b10,
    LBL_MANUAL = 2'b11
  } label_t;

  typedef enum logic [1:0] {
    SA_IDLE  = 2'b00,
    SA_DELAY = 2'b01,
    SA_ALARM = 2'b10,
    SA_MUTED = 2'b11
  } sash_st_t;
endpackage

// ### hw/occupancy_setpoint_alarm_logic.sv
`timescale 1ns/1ns
`include "occ_cfg.svh"
// Notes on behaviour
// R1: unoccupied uses low set point, reduced thresholds
// R2: show high, low or manual label
// R3: 0-300 s delay before low set point
// R4: four thresholds, occupied and reduced pairs
// R5: four-digit password, default zeros, guards config
// R6: enter held five seconds opens menu
// R7: detector relearns background every three minutes
// R8: input 2 is occupancy contact when configured
// R9: input 3 read as temperature when configured
// R10: temperature shown in Celsius or Fahrenheit
// R11: low limit 0..high, high limit low..100; code clamps high to 0..100 and pulls low down to high
// R12: offset -5..+5 C added to temperature
// R13: show-temperature flag shows or hides reading
// R14: selectable relays for low and high alarms
// R15: sash open, unoccupied, after delay raises alarm
// R16: repeat option re-raises alarm periodically
// R17: sash from position sensor or micro switch
// R18: muted alarm resounds after repeat time
// R19: occupied or sash closed clears alarm
// R20: timers use one-second ticks, restart on drop
// R21: relays follow temperature limits while exceeded
module occupancy_setpoint_alarm_logic #(
  parameter int unsigned TICK_CYCLES = `CLK_HZ * `TICK_S,
  parameter int unsigned HOLD_CYCLES = `CLK_HZ * `HOLD_S
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite slave
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // pins and sensor values
  input  wire logic               occupancy_contact_input,
  input  wire logic               sash_switch_in,
  input  wire logic               enter_btn_in,
  input  wire logic signed [15:0] temp_raw,
  input  wire logic [15:0]        sash_height,
  // outputs
  output occ_pkg::airflow_t       airflow,
  output occ_pkg::label_t         label,
  output logic                    menu_active,
  output logic                    sash_alarm,
  output logic [3:0]              relay,
  output logic signed [15:0]      temp_disp,
  output logic                    temp_shown
);
  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                               input logic signed [15:0] lo,
                                               input logic signed [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // ******************************
  // input synchronisers
  // ******************************
  logic [2:0] occ_s, sw_s, btn_s;
  logic       occ_q, sw_q, btn_q;

  always_ff @(posedge aclk)
  begin
    occ_s <= {occ_s[1:0], occupancy_contact_input};
    sw_s  <= {sw_s[1:0], sash_switch_in};
    btn_s <= {btn_s[1:0], enter_btn_in};
    if (occ_s[2] == occ_s[1]) occ_q <= occ_s[2];
    if (sw_s[2] == sw_s[1]) sw_q <= sw_s[2];
    if (btn_s[2] == btn_s[1]) btn_q <= btn_s[2];
  end

  // ******************************
  // register bus
  // ******************************
  logic [`CTRL_W-1:0] ctrl_q;
  logic [31:0]        setpt_q, aocc_q, aun_q, dly_q, sash_q, tlim_q, tcfg_q;
  logic [15:0]        pass_q;
  logic               unlock_q, menu_q;
  logic               aw_full_q, w_full_q;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;

  wire wr_fire = aw_full_q && w_full_q && !bvalid;
  wire [31:0] wv = wdata_q;
  wire cfg_ok = unlock_q;  // see R5
  wire a_cfg = awaddr_q inside {`A_CTRL, `A_SETPT, `A_ALM_OCC, `A_ALM_UNOCC,
                                `A_DELAY, `A_SASH, `A_TLIM, `A_TCFG};
  wire a_map = a_cfg || awaddr_q inside {`A_KEY, `A_STATUS};
  wire do_cfg = wr_fire && a_cfg && cfg_ok;
  wire [31:0] m_ctrl = merge(32'(ctrl_q), wv, wstrb_q);
  wire [31:0] m_dly  = merge(dly_q, wv, wstrb_q);
  wire [31:0] m_tlim = merge(tlim_q, wv, wstrb_q);
  wire [31:0] m_tcfg = merge(tcfg_q, wv, wstrb_q);
  wire signed [15:0] t_hi = clamp(m_tlim[31:16], `T_MIN, `T_MAX);  // see R11
  wire signed [15:0] t_lo = clamp(m_tlim[15:0], `T_MIN, t_hi);     // see R11
  wire signed [15:0] ofs_n = clamp(16'(signed'(m_tcfg[7:0])), `OFS_MIN, `OFS_MAX);
  wire [15:0] occ_dly_n = (m_dly[15:0] > `DLY_MAX) ? `DLY_MAX : m_dly[15:0];
  wire key_wr  = wr_fire && awaddr_q == `A_KEY;
  wire mute_wr = wr_fire && awaddr_q == `A_STATUS && wv[`S_MUTE];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OK;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_full_q <= 1'b1;
        awready   <= 1'b0;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_full_q <= 1'b1;
        wready   <= 1'b0;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      if (wr_fire)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= a_map ? `RESP_OK : `RESP_ERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // config writes only land while unlocked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q  <= `RST_CTRL;
      setpt_q <= `RST_SETPT;
      aocc_q  <= `RST_AOCC;   // see R4
      aun_q   <= `RST_AUNOCC; // see R4
      dly_q   <= `RST_DELAY;
      sash_q  <= `RST_SASH;
      tlim_q  <= `RST_TLIM;
      tcfg_q  <= `RST_TCFG;
    end
    else if (do_cfg)
    begin
      unique case (awaddr_q)
        `A_CTRL:      ctrl_q  <= m_ctrl[`CTRL_W-1:0];
        `A_SETPT:     setpt_q <= merge(setpt_q, wv, wstrb_q);
        `A_ALM_OCC:   aocc_q  <= merge(aocc_q, wv, wstrb_q);
        `A_ALM_UNOCC: aun_q   <= merge(aun_q, wv, wstrb_q);
        `A_DELAY:     dly_q   <= {m_dly[31:16], occ_dly_n};  // see R3
        `A_SASH:      sash_q  <= merge(sash_q, wv, wstrb_q);
        `A_TLIM:      tlim_q  <= {t_hi, t_lo};
        `A_TCFG:      tcfg_q  <= {m_tcfg[31:8], ofs_n[7:0]};  // see R12
        default:      ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // ******************************
  // menu entry and password
  // ******************************
  logic [31:0] hold_cnt_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_cnt_q <= 32'h0000_0000;
      menu_q     <= 1'b0;
      unlock_q   <= 1'b0;
      pass_q     <= `RST_PASS;  // see R5
    end
    else
    begin
      if (key_wr && wv[`K_EXIT])
      begin
        menu_q   <= 1'b0;
        unlock_q <= 1'b0;
      end
      else if (key_wr && wv[`K_SETPW] && unlock_q)
        pass_q <= wv[15:0];
      else if (key_wr && menu_q && wv[15:0] == pass_q)
        unlock_q <= 1'b1;  // see R5
      // a hold completing in the exit cycle wins over the exit
      if (!btn_q || menu_q)
        hold_cnt_q <= 32'h0000_0000;
      else if (hold_cnt_q == HOLD_CYCLES - 1)
        menu_q <= 1'b1;  // see R6
      else
        hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
    end
  end

  // ******************************
  // one-second tick
  // ******************************
  logic [31:0] tick_cnt_q;
  logic        tick_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_q     <= tick_cnt_q == TICK_CYCLES - 1;  // see R20
      tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? 32'h0000_0000
                                                      : tick_cnt_q + 32'h0000_0001;
    end
  end

  // ******************************
  // dual set point
  // ******************************
  wire dual    = ctrl_q[`C_DUAL];
  wire manual  = ctrl_q[`C_MANUAL];
  // without a configured contact the cupboard counts as occupied
  wire occ_in  = !(dual && ctrl_q[`C_IN2_OCC]) || occ_q;  // see R8
  logic [15:0] occ_cnt_q;
  logic        low_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      occ_cnt_q <= 16'h0000;
      low_q     <= 1'b0;
    end
    else if (occ_in || manual)
    begin
      occ_cnt_q <= 16'h0000;  // see R20
      low_q     <= 1'b0;      // see R3
    end
    else if (!low_q)
    begin
      if (occ_cnt_q >= dly_q[15:0])
        low_q <= 1'b1;  // see R3
      else if (tick_q)
        occ_cnt_q <= occ_cnt_q + 16'h0001;
    end
  end

  wire occ_pkg::airflow_t af_d = low_q ? {setpt_q[31:16], aun_q[15:0], aun_q[31:16]}
                                       : {setpt_q[15:0], aocc_q[15:0], aocc_q[31:16]};
  wire occ_pkg::label_t lbl_d = !dual ? occ_pkg::LBL_NONE :
                                manual ? occ_pkg::LBL_MANUAL :
                                low_q ? occ_pkg::LBL_LOW : occ_pkg::LBL_HIGH;

  // ******************************
  // close-sash alarm
  // ******************************
  wire sash_open = ctrl_q[`C_SASH_SW] ? sw_q : (sash_height > sash_q[15:0]);  // see R17
  wire sa_cond   = ctrl_q[`C_SASH_EN] && sash_open && !occ_in;
  occ_pkg::sash_st_t sa_q, sa_d;
  logic [15:0]       sa_cnt_q;
  wire [15:0] sa_dly = dly_q[31:16];
  wire [15:0] sa_rep = sash_q[31:16];

  always_comb
  begin
    sa_d = sa_q;
    unique case (sa_q)
      occ_pkg::SA_IDLE:  if (sa_cond) sa_d = occ_pkg::SA_DELAY;
      occ_pkg::SA_DELAY: if (sa_cnt_q >= sa_dly) sa_d = occ_pkg::SA_ALARM;  // see R15
      occ_pkg::SA_ALARM: if (mute_wr) sa_d = occ_pkg::SA_MUTED;
      occ_pkg::SA_MUTED:
        if (ctrl_q[`C_REPEAT] && sa_cnt_q >= sa_rep)
          sa_d = occ_pkg::SA_ALARM;  // see R16 R18
    endcase
    if (!sa_cond)
      sa_d = occ_pkg::SA_IDLE;  // see R19
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sa_q     <= occ_pkg::SA_IDLE;
      sa_cnt_q <= 16'h0000;
    end
    else
    begin
      sa_q <= sa_d;
      if (sa_d != sa_q)
        sa_cnt_q <= 16'h0000;  // see R20
      else if (tick_q)
        sa_cnt_q <= sa_cnt_q + 16'h0001;
    end
  end

  // ******************************
  // temperature
  // ******************************
  wire               t_en   = ctrl_q[`C_IN3_TEMP];  // see R9
  wire signed [15:0] t_corr = temp_raw + 16'(signed'(tcfg_q[7:0]));  // see R12
  wire signed [19:0] t_f    = 20'(t_corr) * `F_NUM / `F_DEN + `F_ZERO;
  wire signed [15:0] t_show = ctrl_q[`C_UNITS_F] ? t_f[15:0] : t_corr;  // see R10
  // limits are held in celsius so a units change leaves them valid
  wire t_lo_alm = t_en && t_corr < $signed(tlim_q[15:0]);   // see R21
  wire t_hi_alm = t_en && t_corr > $signed(tlim_q[31:16]);  // see R21
  wire [3:0] relay_d = ({3'b000, t_lo_alm} << tcfg_q[9:8])
                     | ({3'b000, t_hi_alm} << tcfg_q[13:12]);  // see R14

  // ******************************
  // outputs and read data
  // ******************************
  wire [31:0] status_w = {22'h00_0000, ctrl_q[`C_SHOW_T] && t_en, t_hi_alm, t_lo_alm,
                          unlock_q, menu_q, sa_q == occ_pkg::SA_ALARM, lbl_d, low_q, occ_in};
  wire [31:0] rd_mux =
    (araddr == `A_CTRL)      ? 32'(ctrl_q) :
    (araddr == `A_SETPT)     ? setpt_q :
    (araddr == `A_ALM_OCC)   ? aocc_q :
    (araddr == `A_ALM_UNOCC) ? aun_q :
    (araddr == `A_DELAY)     ? dly_q :
    (araddr == `A_SASH)      ? sash_q :
    (araddr == `A_TLIM)      ? tlim_q :
    (araddr == `A_TCFG)      ? tcfg_q :
    (araddr == `A_STATUS)    ? status_w :
    (araddr == `A_TEMP)      ? {16'h0000, t_show} :
    (araddr == `A_ACT_SP)    ? {16'h0000, airflow.setpt} :
    (araddr == `A_ACT_ALM)   ? {airflow.warn, airflow.low_air} : 32'h0000_0000;
  wire rd_map = araddr inside {`A_CTRL, `A_SETPT, `A_ALM_OCC, `A_ALM_UNOCC, `A_DELAY,
                               `A_SASH, `A_TLIM, `A_TCFG, `A_KEY, `A_STATUS, `A_TEMP,
                               `A_ACT_SP, `A_ACT_ALM};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready     <= 1'b1;
      rvalid      <= 1'b0;
      rdata       <= 32'h0000_0000;
      rresp       <= `RESP_OK;
      airflow     <= '0;
      label       <= occ_pkg::LBL_NONE;
      menu_active <= 1'b0;
      sash_alarm  <= 1'b0;
      relay       <= 4'h0;
      temp_disp   <= 16'sh0000;
      temp_shown  <= 1'b0;
    end
    else
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_mux;
        rresp   <= rd_map ? `RESP_OK : `RESP_ERR;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
      airflow     <= af_d;   // see R1
      label       <= lbl_d;  // see R2
      menu_active <= menu_q;
      sash_alarm  <= sa_d == occ_pkg::SA_ALARM;
      relay       <= relay_d;
      temp_shown  <= ctrl_q[`C_SHOW_T] && t_en;  // see R13
      temp_disp   <= (ctrl_q[`C_SHOW_T] && t_en) ? t_show : 16'sh0000;
    end
  end
endmodule

// ### tb/occ_checker_properties.sv
`timescale 1ns/1ns
// ******************************
// port watcher
// ******************************
module occ_checker #(
  parameter int unsigned HOLD_CYCLES = 50
) (
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // register bus
  input wire logic               awready,
  input wire logic               wready,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic [31:0]        rdata,
  // pins and outputs
  input wire logic               occupancy_contact_input,
  input wire logic               enter_btn_in,
  input wire occ_pkg::airflow_t  airflow,
  input wire occ_pkg::label_t    label,
  input wire logic               menu_active,
  input wire logic               sash_alarm,
  input wire logic signed [15:0] temp_disp,
  input wire logic               temp_shown
);
  // raw hold length, leads the synchronised one
  logic [31:0] held_q;
  logic [31:0] held_d;
  assign held_d = enter_btn_in ? held_q + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge aclk) held_q <= held_d;

  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write answer withdrawn early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed before taken");
  AST_B_ORDER: assert property ($rose(bvalid) |-> $past(!awready && !wready))
    else $error("write answer without a taken request");
  AST_OCC_CLEAR: assert property (occupancy_contact_input [*8] |=> !sash_alarm)
    else $error("sash alarm while occupied");
  // the pin needs sync and state hops before it reaches the outputs
  AST_SASH_RAISE: assert property ($rose(sash_alarm)
    |-> $past(!occupancy_contact_input, 5))
    else $error("sash alarm raised while occupied");
  AST_MENU_HOLD: assert property ($rose(menu_active) |-> held_q >= HOLD_CYCLES)
    else $error("menu opened before the hold time");
  AST_LOW_AFTER_LOSS: assert property ($changed(label) && label == occ_pkg::LBL_LOW
    |-> $past(!occupancy_contact_input, 6))
    else $error("low set point while occupied");
  AST_SP_SWITCH: assert property ($past(label) == occ_pkg::LBL_HIGH
    && label == occ_pkg::LBL_LOW |-> ##[0:1] airflow != $past(airflow, 3))
    else $error("set point kept on occupancy change");
  AST_TEMP_HIDDEN: assert property (!temp_shown |-> temp_disp == 16'sh0000)
    else $error("hidden temperature still driven");

  COV_MENU: cover property ($rose(menu_active));
  COV_ALARM: cover property ($rose(sash_alarm));
  COV_LOW: cover property ($rose(label == occ_pkg::LBL_LOW));
endmodule

bind occupancy_setpoint_alarm_logic occ_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready), .bvalid(bvalid),
  .bready(bready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .occupancy_contact_input(occupancy_contact_input), .enter_btn_in(enter_btn_in),
  .airflow(airflow), .label(label), .menu_active(menu_active), .sash_alarm(sash_alarm),
  .temp_disp(temp_disp), .temp_shown(temp_shown));

// ### tb/occ_sensor_model.sv
`timescale 1ns/1ns
// ******************************
// detector and sash/temperature sensors
// ******************************
module occ_sensor_model #(
  parameter int unsigned LEARN_CYCLES   = 20,
  parameter int unsigned RELEARN_CYCLES = 3000
) (
  // bench commands
  input  wire logic               aclk,
  input  wire logic               present,
  input  wire logic               slow,
  input  wire logic               open_cmd,
  input  wire logic signed [15:0] temp_cmd,
  input  wire logic [15:0]        height_cmd,
  // sensor pins
  output logic                    occupancy_contact_input = 1'b0,
  output logic                    sash_switch_in,
  output logic signed [15:0]      temp_raw,
  output logic [15:0]             sash_height
);
  int unsigned up_q = 0;
  logic [3:0]  lag_q = 4'h0;
  always @(posedge aclk)
  begin
    up_q  <= up_q + 1;
    lag_q <= {lag_q[2:0], present};
    // blind while learning; relearn cycle absorbs, so output holds
    if (up_q < LEARN_CYCLES) occupancy_contact_input <= 1'b0;
    else if (up_q % RELEARN_CYCLES != 0) occupancy_contact_input <= slow ? lag_q[3] : present;
  end
  assign sash_switch_in = open_cmd;
  assign temp_raw       = temp_cmd;
  assign sash_height    = height_cmd;
endmodule

// ### tb/occupancy_setpoint_alarm_logic_test.sv
`timescale 1ns/1ns
`include "occ_cfg.svh"
module occupancy_setpoint_alarm_logic_test;
  localparam int unsigned TICK = 10;
  localparam int unsigned HOLD = 50;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, enter_btn_in = 1'b0, present = 1'b1, slow = 1'b0;
  logic open_cmd = 1'b0, awready, wready, bvalid, arready, rvalid, occ_pin, sw_pin;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [15:0] height_cmd = 16'h0032, sash_height;
  logic [1:0]  bresp, rresp;
  logic [3:0]  relay_o;
  logic signed [15:0] temp_cmd = 16'sh00C8, temp_raw, t;
  logic [65:0] note;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  int num_errors = 0, checks = 0, cyc = 0;

  always #4 aclk = ~aclk;

  occupancy_setpoint_alarm_logic #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .occupancy_contact_input(occ_pin), .sash_switch_in(sw_pin), .enter_btn_in(enter_btn_in),
    .temp_raw(temp_raw), .sash_height(sash_height), .airflow(), .label(), .menu_active(),
    .sash_alarm(), .relay(relay_o), .temp_disp(), .temp_shown());

  occ_sensor_model sens_u (
    .aclk(aclk), .present(present), .slow(slow), .open_cmd(open_cmd), .temp_cmd(temp_cmd),
    .height_cmd(height_cmd), .occupancy_contact_input(occ_pin), .sash_switch_in(sw_pin),
    .temp_raw(temp_raw), .sash_height(sash_height));

  // ******************************
  // bus master and result watcher
  // ******************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OK);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (awvalid && !awready || wvalid && !wready);
    // a late bready makes the slave hold its answer
    repeat ($urandom_range(2)) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] r = `RESP_OK);
    rq.push_back({r, m, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      note = rq.pop_front();
      cmp({rresp, rdata & note[63:32]}, {note[65:64], note[31:0] & note[63:32]});
    end
    if (bvalid && bready) cmp({bresp, 32'h0000_0000}, {bq.pop_front(), 32'h0000_0000});
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // cycle ceiling well above the whole sequence
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // ******************************
  // sequence
  // ******************************
  initial
  begin
    void'($urandom(76));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wr(`A_CTRL, 32'h0000_0157);
    rd(`A_CTRL, 32'h0000_0000);
    wr(8'h24, 32'h0000_0000, `RESP_ERR);
    rd(8'h3C, 32'h0000_0000, '1, `RESP_ERR);
    @(posedge aclk) enter_btn_in <= 1'b1;
    repeat (30) @(posedge aclk);
    enter_btn_in <= 1'b0;
    rd(`A_STATUS, 32'h0000_0000, 32'h0000_0020);
    @(posedge aclk) enter_btn_in <= 1'b1;
    repeat (HOLD + 20) @(posedge aclk);
    enter_btn_in <= 1'b0;
    rd(`A_STATUS, 32'h0000_0020, 32'h0000_0020);
    wr(`A_KEY, 32'h0000_1234);
    rd(`A_STATUS, 32'h0000_0000, 32'h0000_0040);
    wr(`A_KEY, 32'h0000_0000);
    rd(`A_STATUS, 32'h0000_0040, 32'h0000_0040);
    wr(`A_DELAY, 32'h0002_0190);
    rd(`A_DELAY, 32'h0002_012C);
    wr(`A_DELAY, 32'h0002_0003);
    wr(`A_TLIM, 32'h07D0_0032);
    rd(`A_TLIM, 32'h03E8_0032);
    wr(`A_TLIM, 32'h012C_0190);
    rd(`A_TLIM, 32'h012C_012C);
    wr(`A_TLIM, 32'h012C_0096);
    wr(`A_SASH, 32'h0002_0064);
    wr(`A_TCFG, 32'h0000_1014);
    wr(`A_CTRL, 32'h0000_0157);
    rd(`A_ACT_SP, 32'h0000_0032, 32'h0000_FFFF);
    rd(`A_STATUS, 32'h0000_0005, 32'h0000_000F);
    // late detector: occupancy edges land four cycles later
    @(posedge aclk) slow <= 1'b1;
    repeat (6) @(posedge aclk);
    present <= 1'b0;
    repeat (15) @(posedge aclk);
    present <= 1'b1;
    repeat (8) @(posedge aclk);
    present <= 1'b0;
    repeat (15) @(posedge aclk);
    rd(`A_ACT_SP, 32'h0000_0032, 32'h0000_FFFF);
    repeat (40) @(posedge aclk);
    rd(`A_ACT_SP, 32'h0000_001E, 32'h0000_FFFF);
    rd(`A_ACT_ALM, 32'h001B_0018);
    rd(`A_STATUS, 32'h0000_000A, 32'h0000_000F);
    wr(`A_CTRL, 32'h0000_01D7);
    rd(`A_STATUS, 32'h0000_000C, 32'h0000_000C);
    rd(`A_ACT_SP, 32'h0000_0032, 32'h0000_FFFF);
    wr(`A_CTRL, 32'h0000_0157);
    t = 16'sh008C + 16'($urandom_range(129));
    @(posedge aclk) temp_cmd <= t;
    repeat (4) @(posedge aclk);
    rd(`A_TEMP, {16'h0000, t + 16'sh0014}, 32'h0000_FFFF);
    rd(`A_STATUS, 32'h0000_0200, 32'h0000_0380);
    cmp({30'h0000_0000, relay_o}, 34'h0_0000_0000);
    @(posedge aclk) temp_cmd <= 16'sh0064;
    repeat (4) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0080, 32'h0000_0180);
    cmp({30'h0000_0000, relay_o}, 34'h0_0000_0001);
    @(posedge aclk) temp_cmd <= 16'sh0122;
    repeat (4) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0100, 32'h0000_0180);
    cmp({30'h0000_0000, relay_o}, 34'h0_0000_0002);
    @(posedge aclk) temp_cmd <= 16'sh0118;
    wr(`A_CTRL, 32'h0000_015F);
    rd(`A_TEMP, 32'h0000_035C, 32'h0000_FFFF);
    wr(`A_TCFG, 32'h0000_107F);
    rd(`A_TCFG, 32'h0000_1032, 32'h0000_30FF);
    wr(`A_CTRL, 32'h0000_014F);
    rd(`A_STATUS, 32'h0000_0000, 32'h0000_0200);
    @(posedge aclk) height_cmd <= 16'h00C8;
    repeat (5) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0000, 32'h0000_0010);
    repeat (30) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0010, 32'h0000_0010);
    wr(`A_STATUS, 32'h0000_0001);
    rd(`A_STATUS, 32'h0000_0000, 32'h0000_0010);
    repeat (35) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0010, 32'h0000_0010);
    @(posedge aclk) present <= 1'b1;
    repeat (12) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0000, 32'h0000_0010);
    @(posedge aclk) present <= 1'b0;
    repeat (45) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0010, 32'h0000_0010);
    @(posedge aclk) height_cmd <= 16'h0064;
    repeat (8) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0000, 32'h0000_0010);
    wr(`A_CTRL, 32'h0000_016F);
    @(posedge aclk) open_cmd <= 1'b1;
    repeat (40) @(posedge aclk);
    rd(`A_STATUS, 32'h0000_0010, 32'h0000_0010);
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule
